// *** fbod_map.svh ***
// Timing constants and field positions for the flash bus host controller
`ifndef FBOD_MAP_SVH
`define FBOD_MAP_SVH

`define FBOD_CLK_NS        100
`define FBOD_ACC_NS        120
`define FBOD_ACC_CYC       ((`FBOD_ACC_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_WP_NS         50
`define FBOD_WP_CYC        ((`FBOD_WP_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_RP_NS         500
`define FBOD_RP_CYC        ((`FBOD_RP_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_CNT_W         4
`define FBOD_ADDR_W        18
`define FBOD_SA_HI         17
`define FBOD_SA_LO         13

`endif

// *** fbod_pkg.sv ***
// Types for the flash bus host controller
package fbod_pkg;
    typedef enum logic [1:0] {
        FBOD_OP_READ,
        FBOD_OP_WRITE,
        FBOD_OP_RESET
    } fbod_op_t;

    typedef enum {
        FBOD_IDLE,
        FBOD_RD_WAIT,
        FBOD_WR_PULSE,
        FBOD_WR_END,
        FBOD_RST_PULSE
    } fbod_state_t;
endpackage : fbod_pkg

// *** fbod_host.sv ***
// Host-side controller that drives the boot-sector flash bus pins
`timescale 1ns/1ps
`include "fbod_map.svh"

module fbod_host
    import fbod_pkg::*;
#(
    parameter bit TOP_BOOT = 1'b1,
    parameter bit HAS_RESET_PIN = 1'b1
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     arst_n_i,
    // User request
    input  wire logic                     req_valid_i,
    input  wire fbod_op_t                 req_op_i,
    input  wire logic [`FBOD_ADDR_W-1:0]  req_addr_i,
    input  wire logic [7:0]               req_wdata_i,
    output logic                          req_ready_o,
    output logic                          rsp_valid_o,
    output logic [7:0]                    rsp_rdata_o,
    output logic [2:0]                    rsp_sector_o,
    // Flash pins
    output logic [`FBOD_ADDR_W-1:0]       byte_address_o,
    input  wire logic [7:0]               data_pins_i,
    output logic [7:0]                    data_pins_o,
    output logic                          data_pins_oe_o,
    output logic                          chip_en_n_o,
    output logic                          out_en_n_o,
    output logic                          wr_en_n_o,
    output logic                          reset_n_o
);

    // ********************************
    // Sector decode
    // ********************************
    logic [4:0] sa;
    logic [2:0] sec_top;
    logic [2:0] sec_bot;
    logic [2:0] sector;
    assign sa = req_addr_i[`FBOD_SA_HI:`FBOD_SA_LO];
    assign sec_top = (sa[4:3] != 2'b11) ? {1'b0, sa[4:3]} :
                     !sa[2] ? 3'h3 : sa[1] ? 3'h6 : (sa[0] ? 3'h5 : 3'h4);
    assign sec_bot = (sa[4:3] != 2'b00) ? ({1'b0, sa[4:3]} + 3'h3) :
                     sa[2] ? 3'h3 : !sa[1] ? 3'h0 : (sa[0] ? 3'h2 : 3'h1);
    assign sector = TOP_BOOT ? sec_top : sec_bot;

    // ********************************
    // Bus sequencer
    // ********************************
    fbod_state_t             state_q;
    fbod_state_t             state_d;
    logic [`FBOD_CNT_W-1:0]  cnt_q;
    logic                    take;
    logic                    cnt_done;
    assign take = req_ready_o && req_valid_i;
    assign cnt_done = (cnt_q == '0);

    always_comb begin
        state_d = state_q;
        case (state_q)
            FBOD_IDLE: begin
                if (take) begin
                    case (req_op_i)
                        FBOD_OP_READ:  state_d = FBOD_RD_WAIT;
                        FBOD_OP_WRITE: state_d = FBOD_WR_PULSE;
                        default:       state_d = HAS_RESET_PIN ? FBOD_RST_PULSE : FBOD_IDLE;
                    endcase
                end
            end
            FBOD_RD_WAIT:   if (cnt_done) state_d = FBOD_IDLE;
            FBOD_WR_PULSE:  if (cnt_done) state_d = FBOD_WR_END;
            FBOD_WR_END:    state_d = FBOD_IDLE;
            FBOD_RST_PULSE: if (cnt_done) state_d = FBOD_IDLE;
            default:        state_d = FBOD_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= FBOD_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            if (take) begin
                cnt_q <= (req_op_i == FBOD_OP_READ)  ? `FBOD_CNT_W'(`FBOD_ACC_CYC - 1) :
                         (req_op_i == FBOD_OP_WRITE) ? `FBOD_CNT_W'(`FBOD_WP_CYC - 1) :
                                                       `FBOD_CNT_W'(`FBOD_RP_CYC - 1);
            end else if (!cnt_done) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // ********************************
    // Pin drivers
    // ********************************
    // Pins stay deselected between cycles; array-read needs no setup command
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chip_en_n_o    <= 1'b1;
            out_en_n_o     <= 1'b1;
            wr_en_n_o      <= 1'b1;
            reset_n_o      <= 1'b1;
            data_pins_oe_o <= 1'b0;
            data_pins_o    <= 8'h00;
            byte_address_o <= '0;
            req_ready_o    <= 1'b0;
            rsp_valid_o    <= 1'b0;
            rsp_rdata_o    <= 8'h00;
            rsp_sector_o   <= 3'h0;
        end else begin
            rsp_valid_o <= 1'b0;
            req_ready_o <= (state_d == FBOD_IDLE);
            if (take) begin
                byte_address_o <= req_addr_i;
                rsp_sector_o   <= sector;
                data_pins_o    <= req_wdata_i;
                case (req_op_i)
                    FBOD_OP_READ: begin
                        chip_en_n_o <= 1'b0;
                        out_en_n_o  <= 1'b0;
                    end
                    FBOD_OP_WRITE: begin
                        chip_en_n_o    <= 1'b0;
                        wr_en_n_o      <= 1'b0;
                        data_pins_oe_o <= 1'b1;
                    end
                    default: reset_n_o <= !HAS_RESET_PIN;
                endcase
            end
            if (state_q == FBOD_RD_WAIT && cnt_done) begin
                rsp_rdata_o <= data_pins_i;
                rsp_valid_o <= 1'b1;
                chip_en_n_o <= 1'b1;
                out_en_n_o  <= 1'b1;
            end
            if (state_q == FBOD_WR_PULSE && cnt_done) begin
                wr_en_n_o   <= 1'b1;
                chip_en_n_o <= 1'b1;
            end
            if (state_q == FBOD_WR_END) begin
                data_pins_oe_o <= 1'b0;
                rsp_valid_o    <= 1'b1;
            end
            if (state_q == FBOD_RST_PULSE && cnt_done) begin
                reset_n_o   <= 1'b1;
                // User must restart work the pulse cut short
                rsp_valid_o <= 1'b1;
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_read_levels;
        @(posedge clock_i) disable iff (!arst_n_i)
        !out_en_n_o |-> !chip_en_n_o && wr_en_n_o && reset_n_o && !data_pins_oe_o;
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("bad read levels");

    property p_write_levels;
        @(posedge clock_i) disable iff (!arst_n_i)
        !wr_en_n_o |-> !chip_en_n_o && out_en_n_o && data_pins_oe_o;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("bad write levels");

    property p_no_bus_in_reset;
        @(posedge clock_i) disable iff (!arst_n_i)
        !reset_n_o |-> chip_en_n_o && out_en_n_o && wr_en_n_o;
    endproperty
    a_no_bus_in_reset: assert property (p_no_bus_in_reset) else $error("bus used in reset");

    property p_reset_width;
        @(posedge clock_i) disable iff (!arst_n_i)
        $fell(reset_n_o) |-> !reset_n_o [*5];
    endproperty
    a_reset_width: assert property (p_reset_width) else $error("reset pulse short");

    property p_read_wait;
        @(posedge clock_i) disable iff (!arst_n_i)
        $fell(out_en_n_o) |-> !rsp_valid_o ##1 !rsp_valid_o ##1 rsp_valid_o;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read sampled early");

    property p_write_release;
        @(posedge clock_i) disable iff (!arst_n_i)
        $rose(wr_en_n_o) |-> data_pins_oe_o ##1 !data_pins_oe_o && rsp_valid_o;
    endproperty
    a_write_release: assert property (p_write_release) else $error("data not held");

    property p_top_decode;
        @(posedge clock_i) disable iff (!arst_n_i)
        TOP_BOOT && sa == 5'h1d |-> sector == 3'h5;
    endproperty
    a_top_decode: assert property (p_top_decode) else $error("top decode wrong");

    property p_bot_decode;
        @(posedge clock_i) disable iff (!arst_n_i)
        !TOP_BOOT && sa == 5'h02 |-> sector == 3'h1;
    endproperty
    a_bot_decode: assert property (p_bot_decode) else $error("bottom decode wrong");

endmodule : fbod_host

// *** fbod_flash_model.sv ***
// Behavioural boot-sector flash device for the host bench
`timescale 1ns/1ps

module fbod_flash_model #(
    parameter int ACC_NS = 120
) (
    // Flash pins
    input  wire logic [17:0] byte_address_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       data_o,
    input  wire logic        chip_en_n_i,
    input  wire logic        out_en_n_i,
    input  wire logic        wr_en_n_i,
    input  wire logic        reset_n_i
);
    logic [7:0]  mem [0:(1<<18)-1];
    logic [17:0] addr_q;
    logic [7:0]  last_q = 8'h00;
    logic        wr_act = 1'b0;
    logic        sel;
    logic        sel_late;
    // Read only with ce, oe low, we, reset high; else drive the inverse of the last value
    assign sel = !chip_en_n_i && !out_en_n_i && wr_en_n_i && reset_n_i;
    // Data valid only after a full access time
    assign #(ACC_NS) sel_late = sel;
    // Released bus shows the inverse of the last value, never a held copy
    // Array data only: no identifier or busy status reads here
    assign data_o = (sel && sel_late) ? mem[byte_address_i] : ~last_q;
    always @(data_o or sel_late) if (sel && sel_late) last_q = data_o;
    // Shipped erased
    initial for (int i = 0; i < (1 << 18); i++) mem[i] = 8'hff;
    // Address at the later fall; write only with oe high
    always @(negedge wr_en_n_i or negedge chip_en_n_i) begin
        if (!wr_en_n_i && !chip_en_n_i && out_en_n_i && reset_n_i) begin
            addr_q = byte_address_i;
            wr_act = 1'b1;
        end
    end
    // Data at the earlier rise; no command register in the map
    // Deselect completes the write, never aborts it
    // No command sequence to break, so array-read is never left
    always @(posedge wr_en_n_i or posedge chip_en_n_i) begin
        if (wr_act) mem[addr_q] = data_i;
        wr_act = 1'b0;
    end
    // Reset aborts a write in progress; logic levels only, no unprotect
    always @(negedge reset_n_i) wr_act = 1'b0;
endmodule : fbod_flash_model

// *** fbod_host_tb.sv ***
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps

module fbod_host_tb;
    import fbod_pkg::*;
    logic clock_i = 1'b0, arst_n_i = 1'b0, req_valid_i = 1'b0, req_ready_o, rsp_valid_o;
    fbod_op_t req_op_i = FBOD_OP_READ;
    logic [17:0] req_addr_i = 18'h00000, byte_address_o;
    logic [7:0]  req_wdata_i = 8'h00, rsp_rdata_o, data_pins_o, flash_o, bus;
    logic [2:0]  rsp_sector_o;
    logic        data_pins_oe_o, chip_en_n_o, out_en_n_o, wr_en_n_o, reset_n_o;
    int          fails = 0, n_checks = 0, rst_lo = 0;
    int          ref_mem [int];
    logic [17:0] a;
    logic [7:0]  d;
    logic [2:0]  bot_sec;
    logic        bot_rst_n;
    int          bot_lo = 0;
    always #50 clock_i = ~clock_i;
    assign bus = data_pins_oe_o ? data_pins_o : flash_o;
    fbod_host uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .rsp_sector_o(rsp_sector_o), .byte_address_o(byte_address_o), .data_pins_i(bus),
        .data_pins_o(data_pins_o), .data_pins_oe_o(data_pins_oe_o), .chip_en_n_o(chip_en_n_o),
        .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o), .reset_n_o(reset_n_o));
    fbod_flash_model flash (.byte_address_i(byte_address_o), .data_i(data_pins_o),
        .data_o(flash_o), .chip_en_n_i(chip_en_n_o), .out_en_n_i(out_en_n_o),
        .wr_en_n_i(wr_en_n_o), .reset_n_i(reset_n_o));
    // Bottom layout, no reset pin: mirrors uut on the same requests
    fbod_host #(.TOP_BOOT(1'b0), .HAS_RESET_PIN(1'b0)) uut_bot (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(), .rsp_valid_o(),
        .rsp_rdata_o(), .rsp_sector_o(bot_sec), .byte_address_o(), .data_pins_i(bus),
        .data_pins_o(), .data_pins_oe_o(), .chip_en_n_o(), .out_en_n_o(), .wr_en_n_o(),
        .reset_n_o(bot_rst_n));
    // ****************************************
    // Compare and verdict
    // ****************************************
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    function automatic int top_sector(input logic [17:0] x);
        if (x[17:16] != 2'b11) return x[17:16];
        if (!x[15]) return 3;
        return x[14] ? 6 : 4 + x[13];
    endfunction : top_sector
    function automatic int bot_sector(input logic [17:0] x);
        if (x[17:16] != 2'b00) return 3 + x[17:16];
        if (x[15]) return 3;
        return x[14] ? 1 + x[13] : 0;
    endfunction : bot_sector
    // Strobe combinations watched at every cycle; reset low time counted
    always @(negedge clock_i) begin
        if (!reset_n_o) rst_lo++;
        if (bot_rst_n !== 1'b1) bot_lo++;
        if (!wr_en_n_o) check({chip_en_n_o, out_en_n_o}, 18'h1);
        if (!out_en_n_o) check({wr_en_n_o, data_pins_oe_o}, 18'h2);
    end
    // ****************************************
    // Bus operation with latency count
    // ****************************************
    task automatic do_op(input fbod_op_t op, input logic [17:0] x, input logic [7:0] w,
                         input int lat);
        int n;
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_op_i <= op;
        req_addr_i <= x;
        req_wdata_i <= w;
        n = 0;
        @(negedge clock_i);
        while (req_ready_o !== 1'b1 && n < 20) begin @(negedge clock_i); n++; end
        if (req_ready_o !== 1'b1) begin fails++; print_verdict(); end
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        n = 0;
        do begin @(negedge clock_i); n++; end while (rsp_valid_o !== 1'b1 && n < 20);
        if (n >= 20) begin fails++; print_verdict(); end
        check(n, lat);
        check(rsp_sector_o, top_sector(x));
        check(bot_sec, bot_sector(x));
    endtask : do_op
    initial begin
        void'($urandom(32'hb5235f7e));
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        // Erased reads right after reset, no command first
        do_op(FBOD_OP_READ, 18'h3c000, 8'h00, 3);
        check(rsp_rdata_o, 8'hff);
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? 18'h3ffff : (i == 1) ? 18'h05abc : (i == 2) ? 18'h3a123 : 18'($urandom);
            d = 8'($urandom);
            do_op(FBOD_OP_WRITE, a, d, 3);
            ref_mem[a] = d;
            do_op(FBOD_OP_READ, a, 8'h00, 3);
            check(rsp_rdata_o, ref_mem[a]);
        end
        $display("test rw done");
        rst_lo = 0;
        do_op(FBOD_OP_RESET, 18'h00000, 8'h00, 6);
        check(rst_lo, 5);
        check(bot_lo, 0);
        // Host reset mid-run: strobes idle, then array-read with no command
        @(posedge clock_i);
        arst_n_i <= 1'b0;
        @(negedge clock_i);
        check({chip_en_n_o, out_en_n_o, wr_en_n_o, reset_n_o, req_ready_o}, 18'h1e);
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        do_op(FBOD_OP_READ, 18'h3ffff, 8'h00, 3);
        check(rsp_rdata_o, ref_mem[18'h3ffff]);
        $display("test reset done");
        print_verdict();
    end
endmodule : fbod_host_tb
